// ==== design/pfr_pkg.sv ====
// package for the processor flags register block
package pfr_pkg;
  // bit positions in the processor flags register
  localparam int BIT_CARRY = 0;
  localparam int BIT_NIBBLE = 1;
  localparam int BIT_ZERO = 2;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_WDOG = 4;
  localparam int BIT_BANK = 5;
  localparam int BIT_UPAGE = 6;
  localparam int BIT_IPAGE = 7;
  // reset value: page bits clear, both reset-cause flags set, alu flags 0
  localparam logic [7:0] FLAGS_RESET = 8'h18;
  // data-memory bank bases for direct addressing
  localparam logic [7:0] BANK0_BASE = 8'h00;
  localparam logic [7:0] BANK1_BASE = 8'h80;
  // direct address field width
  localparam int DADDR_W = 7;

  // alu operation classes by their effect on the flags
  typedef enum logic [2:0] {
    PFR_OP_NONE = 3'b000, // no flag change (bit ops, swap, copy out)
    PFR_OP_ADD = 3'b001,  // add: zero, nibble and msb carry
    PFR_OP_SUB = 3'b010,  // subtract: borrows in inverted polarity
    PFR_OP_ZONLY = 3'b011,// logic ops, zero flag only
    PFR_OP_CLEAR = 3'b100 // register zero operation
  } pfr_op_type;

  // one executing instruction as seen by the flags register
  typedef struct packed {
    logic valid;           // instruction executes this cycle
    pfr_op_type op;        // flag class of the operation
    logic [7:0] opA;       // first operand (file or literal)
    logic [7:0] opB;       // second operand (working register)
    logic dstFlags;        // destination is the flags register
    logic [7:0] wrData;    // value the instruction writes
  } pfr_instr_type;

  // internal power and watchdog events
  typedef struct packed {
    logic kick;    // watchdog kick operation
    logic sleep;   // sleep operation
    logic timeout; // watchdog timer timeout
  } pfr_event_type;
endpackage

// ==== design/pfr_flags.sv ====
// processor flags register with alu flag update and bank select
//
// Notes on behaviour
// - flags register may be the destination of any instruction, like others
// - destination writes to zero, nibble, msb flags lose to op results
// - instruction writes never change watchdog-expiry or sleep-entered flags
// - register zero op on flags yields 000u uluu
// - subtraction uses msb and nibble flags as inverted borrow outputs
// - bank bit set selects 80h-FFh, clear selects 00h-7Fh
// - watchdog-expiry set by power-up, kick, sleep; cleared by timeout
// - sleep-entered set by power-up or kick; cleared by sleep
// - nibble flag is carry from bit 3, msb flag carry from bit 7
`timescale 1ns/1ps
`default_nettype none
module pfr_flags
  import pfr_pkg::*;
(
  input wire logic clk_sys,               // core clock, 100 MHz
  input wire logic rst,                   // async power-on reset
  input wire pfr_instr_type instr,        // executing instruction
  input wire pfr_event_type events,       // internal reset-cause events
  input wire logic [DADDR_W-1:0] dirAddr, // direct address from opcode
  output logic [7:0] flags,               // processor flags register
  output logic [7:0] aluResult,           // registered alu result
  output logic [7:0] dataAddr             // banked data-memory address
);

  logic [7:0] next_flags;
  logic [7:0] next_aluResult;
  logic [7:0] next_dataAddr;
  logic [8:0] sum;
  logic [4:0] lowSum;
  logic [7:0] result;
  logic affectsZero;
  logic affectsCarry;

  // alu: subtraction adds the two's complement of the second operand
  always_comb begin
    sum = 9'h000;
    lowSum = 5'h00;
    result = 8'h00;
    affectsZero = 1'b0;
    affectsCarry = 1'b0;
    unique case (instr.op)
      PFR_OP_ADD: begin
        sum = {1'b0, instr.opA} + {1'b0, instr.opB};
        lowSum = {1'b0, instr.opA[3:0]} + {1'b0, instr.opB[3:0]};
        result = sum[7:0];
        affectsZero = 1'b1;
        affectsCarry = 1'b1;
      end
      PFR_OP_SUB: begin
        // carry set means no borrow, so borrow polarity is inverted
        sum = {1'b0, instr.opA} + {1'b0, ~instr.opB} + 9'h001;
        lowSum = {1'b0, instr.opA[3:0]} + {1'b0, ~instr.opB[3:0]}
                 + 5'h01;
        result = sum[7:0];
        affectsZero = 1'b1;
        affectsCarry = 1'b1;
      end
      PFR_OP_ZONLY: begin
        result = instr.wrData;
        affectsZero = 1'b1;
      end
      PFR_OP_CLEAR: begin
        result = 8'h00;
        affectsZero = 1'b1;
      end
      PFR_OP_NONE: begin
        result = instr.wrData;
      end
      default: begin
        result = instr.wrData;
      end
    endcase
  end

  // flags next value: write, then alu flags, then protected event bits
  always_comb begin
    next_flags = flags;
    next_aluResult = aluResult;
    if (instr.valid) begin
      next_aluResult = result;
      if (instr.dstFlags) begin
        // any instruction may target the flags register
        next_flags[7:5] = result[7:5];
        // flag-updating ops block the write to the low three bits
        if (!affectsZero) begin
          next_flags[2:0] = result[2:0];
        end
        if (instr.op == PFR_OP_CLEAR) begin
          next_flags[7:5] = 3'b000;
        end
      end
      if (affectsZero) begin
        next_flags[BIT_ZERO] = (result == 8'h00);
      end
      if (affectsCarry) begin
        next_flags[BIT_NIBBLE] = lowSum[4];
        next_flags[BIT_CARRY] = sum[8];
      end
    end
    // reset-cause flags follow only internal events
    if (events.timeout) begin
      next_flags[BIT_WDOG] = 1'b0;
    end else if (events.kick || events.sleep) begin
      next_flags[BIT_WDOG] = 1'b1;
    end
    if (events.kick) begin
      next_flags[BIT_SLEEP] = 1'b1;
    end else if (events.sleep) begin
      next_flags[BIT_SLEEP] = 1'b0;
    end
  end

  // bank bit extends the direct address; page bits are not used
  always_comb begin
    next_dataAddr = (next_flags[BIT_BANK] ? BANK1_BASE : BANK0_BASE)
                    | {1'b0, dirAddr};
  end

  // register stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags <= FLAGS_RESET;
      aluResult <= 8'h00;
      dataAddr <= 8'h00;
    end else begin
      flags <= next_flags;
      aluResult <= next_aluResult;
      dataAddr <= next_dataAddr;
    end
  end

  // assertions
  property p_protect;
    @(posedge clk_sys) disable iff (rst)
      (instr.valid && instr.dstFlags && !events.kick && !events.sleep
       && !events.timeout) |=> flags[4:3] == $past(flags[4:3]);
  endproperty
  a_protect: assert property (p_protect)
    else $error("reset-cause flags changed by a write");

  property p_clear;
    @(posedge clk_sys) disable iff (rst)
      (instr.valid && instr.dstFlags && instr.op == PFR_OP_CLEAR)
      |=> flags[7:5] == 3'b000 && flags[2] && flags[1:0] == $past(flags[1:0]);
  endproperty
  a_clear: assert property (p_clear)
    else $error("register zero op gave wrong flags");

  property p_zero;
    @(posedge clk_sys) disable iff (rst)
      (instr.valid && instr.op != PFR_OP_NONE)
      |=> flags[BIT_ZERO] == (aluResult == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag disagrees with result");

  property p_addCarry;
    @(posedge clk_sys) disable iff (rst)
      (instr.valid && instr.op == PFR_OP_ADD)
      |=> flags[0] == ({1'b0, $past(instr.opA)} + {1'b0, $past(instr.opB)}
          > 9'h0FF);
  endproperty
  a_addCarry: assert property (p_addCarry)
    else $error("carry flag wrong after add");

  property p_subBorrow;
    @(posedge clk_sys) disable iff (rst)
      (instr.valid && instr.op == PFR_OP_SUB)
      |=> flags[0] == ($past(instr.opA) >= $past(instr.opB))
       && flags[1] == ($past(instr.opA[3:0]) >= $past(instr.opB[3:0]));
  endproperty
  a_subBorrow: assert property (p_subBorrow)
    else $error("borrow flags wrong after subtract");

  property p_timeout;
    @(posedge clk_sys) disable iff (rst)
      events.timeout |=> !flags[BIT_WDOG];
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("watchdog-expiry flag not cleared");

  property p_sleep;
    @(posedge clk_sys) disable iff (rst)
      (events.sleep && !events.kick && !events.timeout)
      |=> !flags[BIT_SLEEP] && flags[BIT_WDOG];
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep flags wrong");

  property p_bank;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> dataAddr[7] == flags[BIT_BANK]
            && dataAddr[6:0] == $past(dirAddr);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank address wrong");

  property p_write;
    @(posedge clk_sys) disable iff (rst)
      (instr.valid && instr.dstFlags && instr.op == PFR_OP_NONE)
      |=> flags[7:5] == $past(instr.wrData[7:5])
       && flags[2:0] == $past(instr.wrData[2:0]);
  endproperty
  a_write: assert property (p_write)
    else $error("plain write not stored");

  property p_keepLow;
    @(posedge clk_sys) disable iff (rst)
      (instr.valid && instr.dstFlags
       && (instr.op == PFR_OP_ZONLY || instr.op == PFR_OP_CLEAR))
      |=> flags[1:0] == $past(flags[1:0]);
  endproperty
  a_keepLow: assert property (p_keepLow)
    else $error("write reached blocked carry flags");

  property p_kick;
    @(posedge clk_sys) disable iff (rst)
      (events.kick && !events.timeout)
      |=> flags[BIT_WDOG] && flags[BIT_SLEEP];
  endproperty
  a_kick: assert property (p_kick)
    else $error("kick did not set reset-cause flags");

endmodule
`default_nettype wire

// ==== testbench/pfr_core_model.sv ====
// core datapath model issuing instructions and events to the flags block
`timescale 1ns/1ps
`default_nettype none
module pfr_core_model
  import pfr_pkg::*;
(
  input wire logic clk_sys,    // core clock
  output pfr_instr_type instr, // instruction to execute
  output pfr_event_type events // reset-cause events
);
  // idle until told otherwise
  initial begin
    instr = '0;
    events = '0;
  end
  // one instruction for one cycle, page bits always written clear
  task automatic exec(input pfr_op_type op, input logic [7:0] a,
      input logic [7:0] b, input logic dst, input logic [7:0] wd);
    @(posedge clk_sys) #1;
    instr = '{1'b1, op, a, b, dst, wd & 8'h3F};
    @(posedge clk_sys) #1;
    instr = '0;
  endtask
  // one-cycle internal event pulse
  task automatic pulse(input pfr_event_type ev);
    @(posedge clk_sys) #1;
    events = ev;
    @(posedge clk_sys) #1;
    events = '0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the processor flags register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pfr_pkg::*;
  logic clk_sys;
  logic rst;
  logic [DADDR_W-1:0] dirAddr;
  pfr_instr_type instr;
  pfr_event_type events;
  logic [7:0] flags;
  logic [7:0] aluResult;
  logic [7:0] dataAddr;
  int err_count = 0;
  int comparisons = 0;

  pfr_flags uut(.clk_sys(clk_sys), .rst(rst), .instr(instr),
    .events(events), .dirAddr(dirAddr), .flags(flags),
    .aluResult(aluResult), .dataAddr(dataAddr));
  pfr_core_model core(.clk_sys(clk_sys), .instr(instr), .events(events));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic results();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // arithmetic op, then result and low three flags
  task automatic alu(input pfr_op_type op, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] res, input logic [2:0] f);
    core.exec(op, a, b, 1'b0, 8'h00);
    check(aluResult, res);
    check({5'h00, flags[2:0]}, {5'h00, f});
  endtask
  // carries and borrows
  task automatic t_arith();
    alu(PFR_OP_ADD, 8'h0F, 8'h01, 8'h10, 3'b010);
    alu(PFR_OP_ADD, 8'hFF, 8'h01, 8'h00, 3'b111);
    alu(PFR_OP_SUB, 8'h05, 8'h03, 8'h02, 3'b011);
    alu(PFR_OP_SUB, 8'h03, 8'h05, 8'hFE, 3'b000);
  endtask
  // destination writes, protected bits, clear, bank addressing
  task automatic t_write();
    core.exec(PFR_OP_NONE, 8'h00, 8'h00, 1'b1, 8'h27);
    check(flags, 8'h3F);
    dirAddr = 7'h12;
    repeat (2) @(posedge clk_sys);
    #1;
    check(dataAddr, 8'h92);
    core.exec(PFR_OP_ADD, 8'h0F, 8'h01, 1'b1, 8'h00);
    check(flags, 8'h1A);
    core.exec(PFR_OP_NONE, 8'h00, 8'h00, 1'b1, 8'h23);
    core.exec(PFR_OP_CLEAR, 8'h00, 8'h00, 1'b1, 8'h00);
    check(flags, 8'h1F);
    repeat (2) @(posedge clk_sys);
    #1;
    check(dataAddr, 8'h12);
    core.exec(PFR_OP_ZONLY, 8'h00, 8'h00, 1'b1, 8'h20);
    check(flags, 8'h3B);
    core.exec(PFR_OP_ZONLY, 8'h00, 8'h00, 1'b1, 8'h00);
    check(flags, 8'h1F);
  endtask
  // reset-cause events
  task automatic t_events();
    core.pulse('{1'b0, 1'b1, 1'b0});
    check({6'h00, flags[4:3]}, 8'h02);
    core.pulse('{1'b0, 1'b0, 1'b1});
    check({6'h00, flags[4:3]}, 8'h00);
    core.pulse('{1'b1, 1'b0, 1'b0});
    check({6'h00, flags[4:3]}, 8'h03);
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    results();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    dirAddr = '0;
    repeat (8) @(posedge clk_sys);
    #1;
    check(flags, FLAGS_RESET);
    check(aluResult, 8'h00);
    check(dataAddr, 8'h00);
    rst = 1'b0;
    t_arith();
    t_write();
    t_events();
    results();
  end
endmodule
`default_nettype wire
